/* rtl/pkrri_pkg.sv */
package pkrri_pkg;
   // =====================================================================
   // register map (word addresses, one 32-bit register per address)
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_EVENT = 4'h2;
   localparam logic [3:0] ADDR_MASK = 4'h3;
   localparam logic [3:0] ADDR_DEBOUNCE = 4'h4;
   localparam logic [3:0] ADDR_KEYDELAY = 4'h5;
   localparam logic [3:0] ADDR_SEQ = 4'h6;
   // =====================================================================
   // ctrl fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_LOCK_BIT = 2;
   localparam int CTRL_SYSEN_BIT = 3;
   localparam int CTRL_STANDBY_BIT = 4;
   localparam int CTRL_FASTSD_BIT = 5;
   localparam int CTRL_PWRDN_BIT = 6;
   // status fields
   localparam int ST_KEY_BIT = 0;
   localparam int ST_RSTREQ_BIT = 1;
   localparam int ST_PWRDN_BIT = 2;
   localparam int ST_HOSTRST_BIT = 3;
   localparam int ST_RESETMODE_BIT = 4;
   // event / mask fields
   localparam int EV_KEY_BIT = 0;
   localparam int EV_RSTREQ_BIT = 1;
   localparam int EV_WAKE_BIT = 2;
   localparam int EV_WIDTH = 3;
   // =====================================================================
   // reset values
   localparam logic [7:0] CTRL_RST = 8'h08;
   localparam logic [EV_WIDTH-1:0] MASK_RST = 3'h0;
   localparam logic [15:0] DEBOUNCE_RST = 16'h0004;
   localparam logic [23:0] KEYDELAY_RST = 24'h000100;
   localparam logic [7:0] SEQ_NORMAL_RST = 8'h10;
   localparam logic [7:0] SEQ_FAST_RST = 8'h02;
   // =====================================================================
   // key modes, sequencer states and key press states
   typedef enum logic [1:0] {
      PKRRI_KEY_PRESS = 2'h0,
      PKRRI_KEY_TIMED = 2'h1,
      PKRRI_KEY_OFF = 2'h2,
      PKRRI_KEY_STBY = 2'h3
   } pkrri_mode_t;
   typedef enum {PKRRI_RUN, PKRRI_RSTSEQ, PKRRI_RESET} pkrri_seq_t;
   typedef enum {PKRRI_KIDLE, PKRRI_KHELD, PKRRI_KLONG} pkrri_key_t;
endpackage

/* rtl/pkrri_deb_if.sv */
`timescale 1ns/1ps
interface pkrri_deb_if;
   logic [15:0] debTime;
   logic rawLevel;
   logic cleanLevel;
   logic fell;
   logic rose;
   modport owner (output debTime, output rawLevel, input cleanLevel, input fell, input rose);
   modport filter (input debTime, input rawLevel, output cleanLevel, output fell, output rose);
endinterface

/* rtl/pkrri_debounce.sv */
`timescale 1ns/1ps
module pkrri_debounce (
   input wire logic core_clk,
   input wire logic srst,
   pkrri_deb_if.filter deb
);
   logic [1:0] sync_r;
   logic stable_r;
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   logic differs;
   logic accept;
   assign differs = sync_r[1] != stable_r;
   // level must differ for debTime+1 cycles in a row before it is taken
   assign accept = differs && (cnt_r >= deb.debTime);
   assign cnt_nxt = differs ? cnt_r + 16'h0001 : 16'h0000;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         sync_r <= 2'h3;
         stable_r <= 1'b1;
         cnt_r <= 16'h0000;
      end else begin
         sync_r <= {sync_r[0], deb.rawLevel};
         cnt_r <= accept ? 16'h0000 : cnt_nxt;
         if (accept) begin
            stable_r <= sync_r[1];
         end
      end
   end
   assign deb.cleanLevel = stable_r;
   assign deb.fell = accept && !sync_r[1];
   assign deb.rose = accept && sync_r[1];
endmodule // pkrri_debounce

/* rtl/pkrri_top.sv */
// The Avalon-MM slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module pkrri_top (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic power_key_n,
   input wire logic reset_request_n,
   output logic irq_out_n,
   output logic host_reset_out_n,
   output logic system_enable,
   output logic standby,
   output logic wakeup_pulse
);
   // =====================================================================
   // registers and state
   localparam int EV_W = pkrri_pkg::EV_WIDTH;
   logic [7:0] ctrl_r;
   logic [EV_W-1:0] event_r;
   logic [EV_W-1:0] mask_r;
   logic [15:0] debTime_r;
   logic [23:0] keyDelay_r;
   logic [23:0] keyTimer_r;
   logic [7:0] seqCnt_r;
   logic faultLog_r;
   logic hostRst_r;
   logic wake_r;
   logic rdAck_r;
   logic [31:0] rdData_r;
   pkrri_pkg::pkrri_seq_t seq_r;
   pkrri_pkg::pkrri_key_t key_r;

   pkrri_deb_if keyDeb ();
   pkrri_deb_if rstDeb ();
   // =====================================================================
   // debounce filters, one shared time setting
   assign keyDeb.debTime = debTime_r;
   assign rstDeb.debTime = debTime_r;
   assign keyDeb.rawLevel = power_key_n;
   assign rstDeb.rawLevel = reset_request_n;
   pkrri_debounce uKeyDeb (.core_clk(core_clk), .srst(srst), .deb(keyDeb));
   pkrri_debounce uRstDeb (.core_clk(core_clk), .srst(srst), .deb(rstDeb));
   // =====================================================================
   // bus decode
   wire selCtrl = avs_address == pkrri_pkg::ADDR_CTRL;
   wire selStatus = avs_address == pkrri_pkg::ADDR_STATUS;
   wire selEvent = avs_address == pkrri_pkg::ADDR_EVENT;
   wire selMask = avs_address == pkrri_pkg::ADDR_MASK;
   wire selDeb = avs_address == pkrri_pkg::ADDR_DEBOUNCE;
   wire selDelay = avs_address == pkrri_pkg::ADDR_KEYDELAY;
   wire wrCtrl = avs_write && selCtrl;
   wire wrMask = avs_write && selMask;
   wire wrDeb = avs_write && selDeb;
   wire wrDelay = avs_write && selDelay;
   // read is answered one cycle later; event clear happens on the answer edge
   wire rdDone = avs_read && rdAck_r;
   wire clrEvent = rdDone && selEvent;
   assign avs_waitrequest = avs_read && !rdAck_r;
   // =====================================================================
   // key timing
   pkrri_pkg::pkrri_mode_t keyMode;
   assign keyMode = pkrri_pkg::pkrri_mode_t'(ctrl_r[pkrri_pkg::CTRL_MODE_LSB +: 2]);
   wire inPwrdn = ctrl_r[pkrri_pkg::CTRL_PWRDN_BIT];
   wire keyLock = ctrl_r[pkrri_pkg::CTRL_LOCK_BIT];
   wire keyMasked = mask_r[pkrri_pkg::EV_KEY_BIT];
   wire timedMode = keyMode != pkrri_pkg::PKRRI_KEY_PRESS;
   // timer keeps running through powerdown: no gating by power mode
   wire longHit = key_r == pkrri_pkg::PKRRI_KHELD && keyTimer_r >= keyDelay_r;
   wire shortRel = key_r == pkrri_pkg::PKRRI_KHELD && keyDeb.rose && !longHit;
   wire pressEv = keyDeb.fell && !timedMode;
   wire shortEv = shortRel && timedMode;
   wire longEv = longHit && timedMode;
   wire keyEv = pressEv || shortEv || longEv;
   // lock suppresses mode 00 press and short-press wakeups only; mask suppresses all
   // a hold past the long-press time wakes in every mode, even mode 00 where it is no event
   wire wakeReq = !keyMasked && inPwrdn
                  && ((pressEv || shortEv) && !keyLock || longHit);
   wire rstReqEv = rstDeb.fell;
   wire [EV_W-1:0] evSet = {wakeReq, rstReqEv, keyEv};
   always_ff @(posedge core_clk) begin
      if (srst) begin
         key_r <= pkrri_pkg::PKRRI_KIDLE;
         keyTimer_r <= 24'h000000;
      end else begin
         unique case (key_r)
            pkrri_pkg::PKRRI_KIDLE: begin
               keyTimer_r <= 24'h000000;
               if (keyDeb.fell) begin
                  key_r <= pkrri_pkg::PKRRI_KHELD;
               end
            end
            pkrri_pkg::PKRRI_KHELD: begin
               keyTimer_r <= keyTimer_r + 24'h000001;
               if (longHit) begin
                  key_r <= pkrri_pkg::PKRRI_KLONG;
               end else if (keyDeb.rose) begin
                  key_r <= pkrri_pkg::PKRRI_KIDLE;
               end
            end
            pkrri_pkg::PKRRI_KLONG: begin
               // release after a long hold raises no second event
               if (keyDeb.rose) begin
                  key_r <= pkrri_pkg::PKRRI_KIDLE;
               end
            end
         endcase
      end
   end
   // =====================================================================
   // reset request sequencer
   wire seqDone = seq_r == pkrri_pkg::PKRRI_RSTSEQ && seqCnt_r == 8'h00;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         seq_r <= pkrri_pkg::PKRRI_RUN;
         seqCnt_r <= 8'h00;
         faultLog_r <= 1'b0;
         hostRst_r <= 1'b0;
      end else begin
         unique case (seq_r)
            pkrri_pkg::PKRRI_RUN: begin
               if (rstReqEv) begin
                  seq_r <= pkrri_pkg::PKRRI_RSTSEQ;
                  faultLog_r <= 1'b1;
                  hostRst_r <= 1'b1;
                  seqCnt_r <= ctrl_r[pkrri_pkg::CTRL_FASTSD_BIT]
                     ? pkrri_pkg::SEQ_FAST_RST : pkrri_pkg::SEQ_NORMAL_RST;
               end
            end
            pkrri_pkg::PKRRI_RSTSEQ: begin
               // counter wraps on the last step but is reloaded before next use
               seqCnt_r <= seqCnt_r - 8'h01;
               if (seqDone) begin
                  seq_r <= pkrri_pkg::PKRRI_RESET;
               end
            end
            pkrri_pkg::PKRRI_RESET: begin
               // leaves reset mode once request released and fault log read
               if (rstDeb.cleanLevel && !faultLog_r) begin
                  seq_r <= pkrri_pkg::PKRRI_RUN;
                  hostRst_r <= 1'b0;
               end
            end
         endcase
         if (clrEvent && !rstReqEv) begin
            faultLog_r <= 1'b0;
         end
      end
   end
   // =====================================================================
   // control register with hardware updates
   // hardware updates override a bus write in the same cycle, so no key action is lost
   logic [7:0] ctrl_nxt;
   always_comb begin
      ctrl_nxt = wrCtrl ? avs_writedata[7:0] : ctrl_r;
      if (longEv) begin
         ctrl_nxt[pkrri_pkg::CTRL_LOCK_BIT] = 1'b1;
      end
      if (longEv && keyMode == pkrri_pkg::PKRRI_KEY_OFF) begin
         ctrl_nxt[pkrri_pkg::CTRL_SYSEN_BIT] = 1'b0;
      end
      if (keyMode == pkrri_pkg::PKRRI_KEY_STBY && (shortEv || longEv)) begin
         ctrl_nxt[pkrri_pkg::CTRL_SYSEN_BIT] = 1'b0;
         ctrl_nxt[pkrri_pkg::CTRL_STANDBY_BIT] = shortEv;
      end
      if (wakeReq) begin
         ctrl_nxt[pkrri_pkg::CTRL_PWRDN_BIT] = 1'b0;
      end
   end
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctrl_r <= pkrri_pkg::CTRL_RST;
         mask_r <= pkrri_pkg::MASK_RST;
         debTime_r <= pkrri_pkg::DEBOUNCE_RST;
         keyDelay_r <= pkrri_pkg::KEYDELAY_RST;
      end else begin
         ctrl_r <= ctrl_nxt;
         if (wrMask) mask_r <= avs_writedata[EV_W-1:0];
         if (wrDeb) debTime_r <= avs_writedata[15:0];
         if (wrDelay) keyDelay_r <= avs_writedata[23:0];
      end
   end
   // =====================================================================
   // events, interrupt, bus read
   wire [31:0] statusWord = {27'h0000000, seq_r == pkrri_pkg::PKRRI_RESET, hostRst_r,
                             inPwrdn, faultLog_r, keyDeb.cleanLevel};
   wire [31:0] rdMux = selCtrl ? {24'h000000, ctrl_r}
                     : selStatus ? statusWord
                     : selEvent ? {29'h00000000, event_r}
                     : selMask ? {29'h00000000, mask_r}
                     : selDeb ? {16'h0000, debTime_r}
                     : selDelay ? {8'h00, keyDelay_r}
                     : 32'h00000000;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         event_r <= {EV_W{1'b0}};
         rdAck_r <= 1'b0;
         rdData_r <= 32'h00000000;
         wake_r <= 1'b0;
      end else begin
         // set wins over the read clear in the same cycle
         event_r <= (clrEvent ? {EV_W{1'b0}} : event_r) | evSet;
         rdAck_r <= avs_read && !rdAck_r;
         rdData_r <= rdMux;
         wake_r <= wakeReq;
      end
   end
   assign avs_readdata = rdData_r;
   // level output: stays low until every unmasked event has been read away
   assign irq_out_n = !(|(event_r & ~mask_r));
   assign host_reset_out_n = !hostRst_r;
   assign system_enable = ctrl_r[pkrri_pkg::CTRL_SYSEN_BIT];
   assign standby = ctrl_r[pkrri_pkg::CTRL_STANDBY_BIT];
   assign wakeup_pulse = wake_r;

   // =====================================================================
   // checks
   AST_MASK_BLOCKS_WAKE: assert property (@(posedge core_clk) disable iff (srst)
      mask_r[pkrri_pkg::EV_KEY_BIT] |=> !wake_r)
      else $error("wakeup while key masked");
   AST_PRESS_EVENT: assert property (@(posedge core_clk) disable iff (srst)
      keyDeb.fell && keyMode == pkrri_pkg::PKRRI_KEY_PRESS |=> event_r[0])
      else $error("press event missing");
   AST_LONG_LOCK: assert property (@(posedge core_clk) disable iff (srst)
      longEv |=> ctrl_r[pkrri_pkg::CTRL_LOCK_BIT] && event_r[0])
      else $error("long press did not lock");
   AST_SHORT_EVENT: assert property (@(posedge core_clk) disable iff (srst)
      shortEv |=> event_r[pkrri_pkg::EV_KEY_BIT])
      else $error("short press event missing");
   AST_LONG_OFF: assert property (@(posedge core_clk) disable iff (srst)
      longEv && keyMode == pkrri_pkg::PKRRI_KEY_OFF |=> !system_enable)
      else $error("system enable not cleared");
   AST_SHORT_STBY: assert property (@(posedge core_clk) disable iff (srst)
      shortEv && keyMode == pkrri_pkg::PKRRI_KEY_STBY |=> standby && !system_enable)
      else $error("standby not entered");
   AST_LONG_STBY: assert property (@(posedge core_clk) disable iff (srst)
      longEv && keyMode == pkrri_pkg::PKRRI_KEY_STBY |=> !standby && !system_enable)
      else $error("standby not cleared");
   AST_LOCK_NOWAKE: assert property (@(posedge core_clk) disable iff (srst)
      shortEv && keyLock |=> !wake_r)
      else $error("short press woke with lock");
   AST_LOCK_PRESS: assert property (@(posedge core_clk) disable iff (srst)
      pressEv && keyLock && !longHit |=> !wake_r)
      else $error("locked press woke");
   AST_LONG_WAKE: assert property (@(posedge core_clk) disable iff (srst)
      longHit && inPwrdn && !keyMasked |=> wake_r && !inPwrdn)
      else $error("long press did not wake");
   AST_WAKE_EVENT: assert property (@(posedge core_clk) disable iff (srst)
      wakeReq |=> wake_r && event_r[pkrri_pkg::EV_WAKE_BIT])
      else $error("wakeup event missing");
   AST_KEY_TIMED: assert property (@(posedge core_clk) disable iff (srst)
      keyDeb.fell && key_r == pkrri_pkg::PKRRI_KIDLE |=> key_r == pkrri_pkg::PKRRI_KHELD)
      else $error("key timer not started");
   AST_RSTREQ_EVENT: assert property (@(posedge core_clk) disable iff (srst)
      rstReqEv |=> event_r[pkrri_pkg::EV_RSTREQ_BIT])
      else $error("reset request event missing");
   AST_RST_SEQ: assert property (@(posedge core_clk) disable iff (srst)
      seq_r == pkrri_pkg::PKRRI_RUN && rstReqEv |=> !host_reset_out_n && faultLog_r)
      else $error("reset request not logged");
   AST_RESET_HOLDS: assert property (@(posedge core_clk) disable iff (srst)
      seq_r == pkrri_pkg::PKRRI_RESET |-> !host_reset_out_n)
      else $error("host reset released in reset mode");
   // sequencer reaches reset mode after its load count plus two cycles
   AST_NORMAL_SEQ: assert property (@(posedge core_clk) disable iff (srst)
      seq_r == pkrri_pkg::PKRRI_RUN && rstReqEv && !ctrl_r[pkrri_pkg::CTRL_FASTSD_BIT]
      |-> ##18 seq_r == pkrri_pkg::PKRRI_RESET)
      else $error("reset mode not reached");
   AST_FAST_SEQ: assert property (@(posedge core_clk) disable iff (srst)
      seq_r == pkrri_pkg::PKRRI_RUN && rstReqEv && ctrl_r[pkrri_pkg::CTRL_FASTSD_BIT]
      |-> ##4 seq_r == pkrri_pkg::PKRRI_RESET)
      else $error("fast shutdown not fast");
   AST_IRQ: assert property (@(posedge core_clk) disable iff (srst)
      |(evSet & ~mask_r) && !wrMask |=> !irq_out_n)
      else $error("irq missing");
   AST_STICKY: assert property (@(posedge core_clk) disable iff (srst)
      event_r[0] && !clrEvent |=> event_r[0])
      else $error("key event lost");
   COV_LONG: cover property (@(posedge core_clk) longEv);
   COV_SHORT: cover property (@(posedge core_clk) shortEv);
   COV_RESET: cover property (@(posedge core_clk) seq_r == pkrri_pkg::PKRRI_RESET);
   COV_WAKE: cover property (@(posedge core_clk) wake_r);
   COV_LOCK_WAKE: cover property (@(posedge core_clk) longHit && inPwrdn && keyLock);
endmodule // pkrri_top

/* sim/pkrri_key_host_model.sv */
`timescale 1ns/1ps
// =====================================================================
// push button and host reset request line, both idle high
module pkrri_key_host_model (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic keyPress,
   input wire logic resetAsk,
   output logic power_key_n,
   output logic reset_request_n
);
   // held high through reset so no stray edge reaches the filters
   always_ff @(posedge core_clk) begin
      if (srst) begin
         power_key_n <= 1'b1;
         reset_request_n <= 1'b1;
      end else begin
         power_key_n <= ~keyPress;
         reset_request_n <= ~resetAsk;
      end
   end
endmodule // pkrri_key_host_model

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic power_key_n, reset_request_n, irq_out_n, host_reset_out_n;
   logic system_enable, standby, wakeup_pulse;
   logic keyPress = 1'b0;
   logic resetAsk = 1'b0;
   logic [31:0] rd;
   int errCount = 0;
   int samplesChecked = 0;
   int wakeCount = 0;
   int cycle = 0;
   int tNorm, tFast;
   always #2 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycle <= cycle + 1;
      if (wakeup_pulse === 1'b1) wakeCount <= wakeCount + 1;
   end
   pkrri_top pkrri_top_inst (.core_clk(core_clk), .srst(srst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .power_key_n(power_key_n), .reset_request_n(reset_request_n), .irq_out_n(irq_out_n),
      .host_reset_out_n(host_reset_out_n), .system_enable(system_enable),
      .standby(standby), .wakeup_pulse(wakeup_pulse));
   pkrri_key_host_model pkrri_key_host_model_inst (.core_clk(core_clk), .srst(srst),
      .keyPress(keyPress), .resetAsk(resetAsk), .power_key_n(power_key_n),
      .reset_request_n(reset_request_n));
   // =====================================================================
   // reporting
   task automatic printVerdict();
      $display("checks %0d mismatches %0d", samplesChecked, errCount);
      if (errCount == 0 && samplesChecked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic checkWord(string what, logic [31:0] exp, logic [31:0] got);
      samplesChecked++;
      if (got !== exp) begin
         errCount++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic checkBit(string what, logic exp, logic got);
      checkWord(what, {31'h0, exp}, {31'h0, got});
   endtask
   // =====================================================================
   // bus master: request held until waitrequest is sampled low
   task automatic avAccess(logic wr, logic [3:0] a, logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      if (wr) avs_write <= 1'b1;
      else avs_read <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic readCheck(string what, logic [3:0] a, logic [31:0] m, logic [31:0] exp);
      avAccess(1'b0, a, 32'h0);
      checkWord(what, exp, rd & m);
   endtask
   task automatic press(int hold);
      keyPress <= 1'b1;
      repeat (hold) @(posedge core_clk);
      keyPress <= 1'b0;
      repeat (14) @(posedge core_clk);
   endtask
   // one key press under a given control setting, then events, irq, ctrl and wakeups
   task automatic runKey(string what, logic [7:0] ctrl, int hold, logic [7:0] expCtrl,
                         int expWake, logic expIrqN);
      int w0;
      avAccess(1'b1, pkrri_pkg::ADDR_CTRL, {24'h0, ctrl});
      avAccess(1'b0, pkrri_pkg::ADDR_EVENT, 32'h0);
      w0 = wakeCount;
      press(hold);
      checkBit({what, " irq"}, expIrqN, irq_out_n);
      readCheck({what, " event"}, pkrri_pkg::ADDR_EVENT, 32'h1, 32'h1);
      checkBit({what, " irq clear"}, 1'b1, irq_out_n);
      readCheck({what, " ctrl"}, pkrri_pkg::ADDR_CTRL, 32'h5C, {24'h0, expCtrl});
      checkWord({what, " outs"}, 32'(expCtrl[4:3]), {30'h0, standby, system_enable});
      checkWord({what, " wakeups"}, expWake, wakeCount - w0);
      $display("test %s done", what);
   endtask
   // reset request round trip; returns cycles until reset mode shows in status
   task automatic runReset(logic [7:0] ctrl, output int t);
      int t0;
      avAccess(1'b1, pkrri_pkg::ADDR_CTRL, {24'h0, ctrl});
      resetAsk <= 1'b1;
      t0 = cycle;
      rd = 32'h0;
      while (rd[pkrri_pkg::ST_RESETMODE_BIT] !== 1'b1 && cycle - t0 < 200) begin
         avAccess(1'b0, pkrri_pkg::ADDR_STATUS, 32'h0);
      end
      t = cycle - t0;
      checkWord("reset flags", 32'h1A, rd & 32'h1A);
      checkBit("host reset", 1'b0, host_reset_out_n);
      resetAsk <= 1'b0;
      repeat (12) @(posedge core_clk);
      readCheck("fault event", pkrri_pkg::ADDR_EVENT, 32'h2, 32'h2);
      repeat (4) @(posedge core_clk);
      checkBit("host reset off", 1'b1, host_reset_out_n);
      $display("test reset request done");
   endtask
   // =====================================================================
   // tests
   initial begin
      repeat (5) @(posedge core_clk);
      srst <= 1'b0;
      readCheck("ctrl rst", pkrri_pkg::ADDR_CTRL, 32'hFF, 32'h08);
      readCheck("mask rst", pkrri_pkg::ADDR_MASK, 32'h7, 32'h0);
      readCheck("deb rst", pkrri_pkg::ADDR_DEBOUNCE, 32'hFFFF, 32'h4);
      readCheck("delay rst", pkrri_pkg::ADDR_KEYDELAY, 32'hFFFFFF, 32'h100);
      checkWord("outs rst", 32'hE, {irq_out_n, host_reset_out_n, system_enable, standby});
      avAccess(1'b1, 4'hF, 32'hFFFFFFFF);
      readCheck("unmapped", 4'hF, 32'hFFFFFFFF, 32'h0);
      $display("test reset values done");
      // shorter filter and long-press time keep the run brief
      avAccess(1'b1, pkrri_pkg::ADDR_DEBOUNCE, 32'h2);
      avAccess(1'b1, pkrri_pkg::ADDR_KEYDELAY, 32'h28);
      keyPress <= 1'b1;
      repeat (12) @(posedge core_clk);
      readCheck("key level low", pkrri_pkg::ADDR_STATUS, 32'h1, 32'h0);
      keyPress <= 1'b0;
      repeat (12) @(posedge core_clk);
      readCheck("key level high", pkrri_pkg::ADDR_STATUS, 32'h1, 32'h1);
      $display("test key level done");
      runKey("m0", 8'h08, 15, 8'h08, 0, 1'b0);
      runKey("m0 pd", 8'h48, 15, 8'h08, 1, 1'b0);
      runKey("m1 short", 8'h09, 15, 8'h08, 0, 1'b0);
      runKey("m1 long", 8'h09, 80, 8'h0C, 0, 1'b0);
      runKey("m2 short", 8'h0A, 15, 8'h08, 0, 1'b0);
      runKey("m2 long", 8'h0A, 80, 8'h04, 0, 1'b0);
      runKey("m3 short", 8'h0B, 15, 8'h10, 0, 1'b0);
      runKey("m3 long", 8'h1B, 80, 8'h04, 0, 1'b0);
      runKey("lock short", 8'h4C, 15, 8'h4C, 0, 1'b0);
      runKey("lock long", 8'h4C, 80, 8'h0C, 1, 1'b0);
      avAccess(1'b1, pkrri_pkg::ADDR_MASK, 32'h7);
      runKey("masked", 8'h48, 15, 8'h48, 0, 1'b1);
      avAccess(1'b1, pkrri_pkg::ADDR_MASK, 32'h0);
      runReset(8'h08, tNorm);
      runReset(8'h28, tFast);
      checkBit("fast shorter", 1'b1, tFast + 8 < tNorm);
      printVerdict();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      errCount++;
      printVerdict();
   end
endmodule // tb_top
